// ### design/rtcpit_regs.svh
// Register map, field positions, reset values and timing counts of the RTC compare and PIT block.
`ifndef RTCPIT_REGS_SVH
`define RTCPIT_REGS_SVH

// =============================================================
// Register indices; byte address is four times the index.
`define RTCPIT_IDX_RTC_FLAG 8'h03
`define RTCPIT_IDX_CMP_LO 8'h0c
`define RTCPIT_IDX_CMP_HI 8'h0d
`define RTCPIT_IDX_PIT_CTRL 8'h10
`define RTCPIT_IDX_PIT_STAT 8'h11
`define RTCPIT_IDX_PIT_IEN 8'h12
`define RTCPIT_IDX_PIT_FLAG 8'h13
`define RTCPIT_IDX_PIT_DBG 8'h15

// =============================================================
// Field positions.
`define RTCPIT_CTRL_EN_BIT 0
`define RTCPIT_CTRL_PER_LSB 3
`define RTCPIT_CTRL_PER_MSB 6
`define RTCPIT_STAT_BUSY_BIT 0
`define RTCPIT_IEN_BIT 0
`define RTCPIT_PFLAG_BIT 0
`define RTCPIT_DBG_RUN_BIT 0
`define RTCPIT_CMP_FLAG_BIT 1

// =============================================================
// Reset values.
`define RTCPIT_RST_CMP 16'h0000
`define RTCPIT_RST_BYTE 8'h00

// =============================================================
// Interval codes and timing counts.
`define RTCPIT_PER_OFF 4'h0
`define RTCPIT_PER_RSVD 4'hf
`define RTCPIT_SYNC_TICKS 2'h2

`endif

// ### design/rtcpit_pkg.sv
// Types shared by the RTC compare and PIT block.
`default_nettype none
package rtcpit_pkg;

    // =============================================================
    // Control synchroniser states.
    typedef enum logic [0:0] {
        RTCPIT_SYNC_IDLE = 1'b0,
        RTCPIT_SYNC_BUSY = 1'b1
    } rtcpit_sync_type;

    // Interval selector code.
    typedef logic [3:0] rtcpit_period_type;

endpackage : rtcpit_pkg
`default_nettype wire

// ### design/rtcpit_timer.sv
// Periodic interval counter that raises one event pulse per selected interval.
`default_nettype none
`include "rtcpit_regs.svh"

module rtcpit_timer
    import rtcpit_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Timing and control
    input wire logic rtc_tick,
    input wire logic run,
    input wire logic enable,
    input wire rtcpit_period_type period,
    // Event
    output logic event_q
);

    // =============================================================
    // Interval decode.
    logic [14:0] count_q;
    logic [14:0] count_d;
    logic [14:0] last_count;
    rtcpit_period_type period_q;
    logic active;
    logic restart;
    logic wrap;

    // Intervals double from 4 cycles; off and reserved codes stop the timer.
    assign active = enable && (period != `RTCPIT_PER_OFF) && (period != `RTCPIT_PER_RSVD);
    assign last_count = 15'((32'h1 << (32'(period) + 32'h1)) - 32'h1);
    assign restart = !active || (period != period_q);
    assign wrap = rtc_tick && run && (count_q == last_count);
    assign count_d = restart ? 15'h0000 : (wrap ? 15'h0000 : count_q + 15'h0001);

    // Count RTC ticks only while running and not halted by debug.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 15'h0000;
            period_q <= `RTCPIT_PER_OFF;
            event_q <= 1'b0;
        end else if (ce) begin
            period_q <= period;
            if (restart || (rtc_tick && run)) begin
                count_q <= count_d;
            end
            event_q <= wrap && !restart;
        end
    end

endmodule : rtcpit_timer
`default_nettype wire

// ### design/rtcpit_top.sv
// AHB-Lite register slave with RTC compare match and periodic interrupt timer.
//
// The implementer's own choice: the AHB-Lite register port.
`default_nettype none
`include "rtcpit_regs.svh"

// Contract
// - The 16-bit compare value is held as a low byte register and a high byte register next above it.
// - Bits 6:3 of the timer control register choose the spacing of periodic events in RTC cycles.
// - Interval code 0 gives no event, codes 1 to 14 give 2^(code+1) cycles, and code 15 is reserved.
// - Bit 0 of the timer control register switches the periodic timer on and off.
// - The busy status bit stays 1 while a control write is still being carried into the RTC domain.
// - Bit 0 of the periodic interrupt enable register lets the periodic interrupt through or blocks it.
// - Each periodic event sets bit 0 of the periodic flag register.
// - Writing 1 to the periodic flag clears it and writing 0 leaves it alone.
// - With debug run clear the timer stops and ignores events while the processor is halted.
// - With debug run set the timer keeps running while the processor is halted.
// - The compare match flag is set on an RTC tick when the counter equals the compare value, unless halted with debug run clear.
// - Writing 1 to the compare match flag clears it.
module rtcpit_top
    import rtcpit_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // RTC timing and debug
    input wire logic rtc_tick,
    input wire logic [15:0] counter_value,
    input wire logic debug_halt,
    // Event outputs
    output logic periodic_irq_req,
    output logic compare_match
);

    // =============================================================
    // Byte addresses of the registers.
    localparam logic [9:0] ADDR_RTC_FLAG = {`RTCPIT_IDX_RTC_FLAG, 2'b00};
    localparam logic [9:0] ADDR_CMP_LO = {`RTCPIT_IDX_CMP_LO, 2'b00};
    localparam logic [9:0] ADDR_CMP_HI = {`RTCPIT_IDX_CMP_HI, 2'b00};
    localparam logic [9:0] ADDR_PIT_CTRL = {`RTCPIT_IDX_PIT_CTRL, 2'b00};
    localparam logic [9:0] ADDR_PIT_STAT = {`RTCPIT_IDX_PIT_STAT, 2'b00};
    localparam logic [9:0] ADDR_PIT_IEN = {`RTCPIT_IDX_PIT_IEN, 2'b00};
    localparam logic [9:0] ADDR_PIT_FLAG = {`RTCPIT_IDX_PIT_FLAG, 2'b00};
    localparam logic [9:0] ADDR_PIT_DBG = {`RTCPIT_IDX_PIT_DBG, 2'b00};

    // =============================================================
    // Bus phase state.
    logic wr_pend_q;
    logic rd_pend_q;
    logic [9:0] addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;

    // Register state.
    logic [15:0] compare_value_q;
    logic [7:0] periodic_timer_control_q;
    logic periodic_irq_enable_q;
    logic periodic_irq_flag_q;
    logic debug_run_enable_q;
    logic compare_flag_q;
    logic periodic_irq_req_q;
    logic compare_match_q;

    // Control as seen by the RTC side after synchronisation.
    logic periodic_timer_enable_q;
    rtcpit_period_type period_q;
    rtcpit_sync_type sync_state_q;
    logic [1:0] sync_cnt_q;

    // =============================================================
    // Address phase decode.
    logic addr_valid;
    logic wr_go;
    logic [9:0] haddr_word;
    logic [7:0] wbyte;

    assign addr_valid = hsel && htrans[1] && hready;
    assign wr_go = wr_pend_q;
    assign haddr_word = {haddr[9:2], 2'b00};
    assign wbyte = hwdata[7:0];

    // Data phase write strobes, one per writable register.
    logic we_cmp_lo;
    logic we_cmp_hi;
    logic we_ctrl;
    logic we_ien;
    logic we_pflag;
    logic we_dbg;
    logic we_cflag;

    assign we_cmp_lo = wr_go && (addr_q == ADDR_CMP_LO);
    assign we_cmp_hi = wr_go && (addr_q == ADDR_CMP_HI);
    assign we_ctrl = wr_go && (addr_q == ADDR_PIT_CTRL);
    assign we_ien = wr_go && (addr_q == ADDR_PIT_IEN);
    assign we_pflag = wr_go && (addr_q == ADDR_PIT_FLAG);
    assign we_dbg = wr_go && (addr_q == ADDR_PIT_DBG);
    assign we_cflag = wr_go && (addr_q == ADDR_RTC_FLAG);

    // =============================================================
    // Read data selection; unmapped addresses and reserved bits read as zero.
    logic sync_busy;
    logic [31:0] rdata_mux;

    assign sync_busy = (sync_state_q == RTCPIT_SYNC_BUSY);

    assign rdata_mux =
        (addr_q == ADDR_CMP_LO) ? {24'h000000, compare_value_q[7:0]} :
        (addr_q == ADDR_CMP_HI) ? {24'h000000, compare_value_q[15:8]} :
        (addr_q == ADDR_PIT_CTRL) ? {24'h000000, periodic_timer_control_q} :
        (addr_q == ADDR_PIT_STAT) ? {31'h0, sync_busy} :
        (addr_q == ADDR_PIT_IEN) ? {31'h0, periodic_irq_enable_q} :
        (addr_q == ADDR_PIT_FLAG) ? {31'h0, periodic_irq_flag_q} :
        (addr_q == ADDR_PIT_DBG) ? {31'h0, debug_run_enable_q} :
        (addr_q == ADDR_RTC_FLAG) ? {30'h0, compare_flag_q, 1'b0} :
        32'h00000000;

    // Capture the address phase; reads take one wait state so writes land first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 10'h000;
            hreadyout_q <= 1'b1;
        end else if (ce) begin
            wr_pend_q <= addr_valid && hwrite;
            rd_pend_q <= addr_valid && !hwrite;
            hreadyout_q <= !(addr_valid && !hwrite);
            if (addr_valid) begin
                addr_q <= haddr_word;
            end
        end
    end

    // Load read data at the end of the wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (ce && rd_pend_q) begin
            hrdata_q <= rdata_mux;
        end
    end

    // =============================================================
    // Software-written registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_value_q <= `RTCPIT_RST_CMP;
            periodic_timer_control_q <= `RTCPIT_RST_BYTE;
            periodic_irq_enable_q <= 1'b0;
            debug_run_enable_q <= 1'b0;
        end else if (ce) begin
            if (we_cmp_lo) begin
                compare_value_q[7:0] <= wbyte;
            end
            if (we_cmp_hi) begin
                compare_value_q[15:8] <= wbyte;
            end
            if (we_ctrl) begin
                periodic_timer_control_q <= {1'b0, wbyte[6:3], 2'b00, wbyte[0]};
            end
            if (we_ien) begin
                periodic_irq_enable_q <= wbyte[`RTCPIT_IEN_BIT];
            end
            if (we_dbg) begin
                debug_run_enable_q <= wbyte[`RTCPIT_DBG_RUN_BIT];
            end
        end
    end

    // =============================================================
    // Control synchroniser: a write is applied after two RTC ticks.
    rtcpit_sync_type sync_state_d;
    logic sync_done;

    assign sync_done = sync_busy && rtc_tick && (sync_cnt_q == `RTCPIT_SYNC_TICKS - 2'h1);

    always_comb begin
        sync_state_d = sync_state_q;
        case (sync_state_q)
            RTCPIT_SYNC_IDLE: begin
                if (we_ctrl) begin
                    sync_state_d = RTCPIT_SYNC_BUSY;
                end
            end
            RTCPIT_SYNC_BUSY: begin
                if (sync_done && !we_ctrl) begin
                    sync_state_d = RTCPIT_SYNC_IDLE;
                end
            end
            default: begin
                sync_state_d = RTCPIT_SYNC_IDLE;
            end
        endcase
    end

    // Busy holds until the latest control value reaches the timer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_state_q <= RTCPIT_SYNC_IDLE;
            sync_cnt_q <= 2'h0;
            periodic_timer_enable_q <= 1'b0;
            period_q <= `RTCPIT_PER_OFF;
        end else if (ce) begin
            sync_state_q <= sync_state_d;
            if (we_ctrl || !sync_busy) begin
                sync_cnt_q <= 2'h0;
            end else if (rtc_tick) begin
                sync_cnt_q <= sync_cnt_q + 2'h1;
            end
            if (sync_done && !we_ctrl) begin
                periodic_timer_enable_q <= periodic_timer_control_q[`RTCPIT_CTRL_EN_BIT];
                period_q <= periodic_timer_control_q[`RTCPIT_CTRL_PER_MSB:`RTCPIT_CTRL_PER_LSB];
            end
        end
    end

    // =============================================================
    // Periodic timer.
    logic timer_run;
    logic pit_event;

    // Halted in debug only when debug run is clear.
    assign timer_run = !debug_halt || debug_run_enable_q;

    rtcpit_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .rtc_tick(rtc_tick),
        .run(timer_run),
        .enable(periodic_timer_enable_q),
        .period(period_q),
        .event_q(pit_event)
    );

    // =============================================================
    // Event flags; a new event wins over a clear in the same cycle.
    logic cmp_hit;

    assign cmp_hit = rtc_tick && timer_run && (counter_value == compare_value_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periodic_irq_flag_q <= 1'b0;
            compare_flag_q <= 1'b0;
        end else if (ce) begin
            if (pit_event) begin
                periodic_irq_flag_q <= 1'b1;
            end else if (we_pflag && wbyte[`RTCPIT_PFLAG_BIT]) begin
                periodic_irq_flag_q <= 1'b0;
            end
            if (cmp_hit) begin
                compare_flag_q <= 1'b1;
            end else if (we_cflag && wbyte[`RTCPIT_CMP_FLAG_BIT]) begin
                compare_flag_q <= 1'b0;
            end
        end
    end

    // Registered request and match outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periodic_irq_req_q <= 1'b0;
            compare_match_q <= 1'b0;
        end else if (ce) begin
            periodic_irq_req_q <= periodic_irq_flag_q && periodic_irq_enable_q;
            compare_match_q <= compare_flag_q;
        end
    end

    // =============================================================
    // Outputs.
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0; // Always OKAY.
    assign periodic_irq_req = periodic_irq_req_q;
    assign compare_match = compare_match_q;

endmodule : rtcpit_top
`default_nettype wire

// ### bench/rtcpit_props.sv
// Bus timing and event output checks for the RTC compare and PIT block.
`default_nettype none
module rtcpit_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // RTC timing and events
    input wire logic rtc_tick,
    input wire logic [15:0] counter_value,
    input wire logic debug_halt,
    input wire logic periodic_irq_req,
    input wire logic compare_match
);
    timeunit 1ns;
    timeprecision 1ns;

    // =============================================================
    // Transfers accepted at an edge.
    wire logic taken = hsel & htrans[1] & hready & ce;
    wire logic wr_tk = taken & hwrite;
    wire logic rd_tk = taken & ~hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // =============================================================
    // Assertions.
    a_okay_resp: assert property (hresp == 1'b0) else $error("slave answered other than OKAY");
    a_read_wait: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_write_nowait: assert property (wr_tk |=> hreadyout) else $error("write stalled");
    a_ready_single: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
    a_rdata_hold: assert property ($changed(hrdata) |-> !hreadyout || !$past(hreadyout))
        else $error("read data changed outside a read");
    a_cmp_rise_tick: assert property ($rose(compare_match) |->
        $past(rtc_tick) || $past(rtc_tick, 2) || $past(rtc_tick, 3))
        else $error("compare match rose without a tick");
    a_cmp_fall_write: assert property ($fell(compare_match) |->
        $past(wr_tk, 2) || $past(wr_tk, 3) || $past(wr_tk, 4))
        else $error("compare match fell without a write");
    a_irq_fall_write: assert property ($fell(periodic_irq_req) |->
        $past(wr_tk, 2) || $past(wr_tk, 3) || $past(wr_tk, 4))
        else $error("periodic request fell without a write");

    // Main scenarios reached.
    c_read: cover property (rd_tk);
    c_irq: cover property ($rose(periodic_irq_req));
    c_cmp: cover property ($rose(compare_match));
endmodule : rtcpit_props

bind rtcpit_top rtcpit_props i_props (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rtc_tick(rtc_tick), .counter_value(counter_value), .debug_halt(debug_halt),
    .periodic_irq_req(periodic_irq_req), .compare_match(compare_match));
`default_nettype wire

// ### bench/testbench.sv
// Directed register, timer, debug and compare tests for the RTC compare and PIT block.
`default_nettype none
`include "rtcpit_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] r_ctl = `RTCPIT_IDX_PIT_CTRL;
    localparam logic [7:0] r_flg = `RTCPIT_IDX_PIT_FLAG;
    localparam logic [7:0] r_ien = `RTCPIT_IDX_PIT_IEN;
    localparam logic [7:0] r_dbg = `RTCPIT_IDX_PIT_DBG;
    localparam logic [7:0] r_cfl = `RTCPIT_IDX_RTC_FLAG;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic rtc_tick = 1'b0, debug_halt = 1'b0, ce = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [15:0] counter_value = 16'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, periodic_irq_req, compare_match;
    int n_mismatch = 0;
    int tests_run = 0;

    // Free running clock.
    always #5 hclk = ~hclk;

    // Device under test; hready loops back from the only slave.
    rtcpit_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rtc_tick(rtc_tick),
        .counter_value(counter_value), .debug_halt(debug_halt),
        .periodic_irq_req(periodic_irq_req), .compare_match(compare_match));

    // =============================================================
    // Helpers.
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One single AHB transfer; entered and left just after a rising edge.
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask : wr

    task rchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 8'h0);
        chk(what, exp, rd);
    endtask : rchk

    task ticks(input int n);
        repeat (n) begin
            rtc_tick <= 1'b1;
            @(posedge hclk);
            rtc_tick <= 1'b0;
            @(posedge hclk);
        end
    endtask : ticks

    // Stops the timer, applies a new control value and clears the flag.
    task pit_setup(input logic [7:0] c);
        wr(r_ctl, 8'h0);
        ticks(2);
        wr(r_ctl, c);
        ticks(2);
        wr(r_flg, 8'h1);
    endtask : pit_setup

    // =============================================================
    // Scenarios.
    task s_regs;
        logic [7:0] ix [7] = '{`RTCPIT_IDX_CMP_LO, `RTCPIT_IDX_CMP_HI, r_ctl,
            `RTCPIT_IDX_PIT_STAT, r_ien, r_flg, r_dbg};
        foreach (ix[i]) rchk(ix[i], 32'h0, "reset value");
        wr(`RTCPIT_IDX_CMP_LO, 8'ha5);
        wr(`RTCPIT_IDX_CMP_HI, 8'h3c);
        rchk(`RTCPIT_IDX_CMP_LO, 32'ha5, "compare low");
        rchk(`RTCPIT_IDX_CMP_HI, 32'h3c, "compare high");
        wr(8'h20, 8'hff);
        rchk(8'h20, 32'h0, "unmapped");
        wr(`RTCPIT_IDX_PIT_STAT, 8'hff);
        rchk(`RTCPIT_IDX_PIT_STAT, 32'h0, "status read only");
    endtask : s_regs

    task s_sync;
        wr(r_ctl, 8'h0);
        ticks(2);
        wr(r_ctl, 8'h09);
        rchk(`RTCPIT_IDX_PIT_STAT, 32'h1, "busy after write");
        ticks(1);
        rchk(`RTCPIT_IDX_PIT_STAT, 32'h1, "busy after one tick");
        ticks(1);
        rchk(`RTCPIT_IDX_PIT_STAT, 32'h0, "busy after two ticks");
    endtask : s_sync

    task s_period;
        logic [7:0] c;
        for (int p = 1; p <= 3; p++) begin
            c = 8'((p << 3) | 1);
            pit_setup(c);
            rchk(r_ctl, {24'h0, c}, "control");
            ticks((2 ** (p + 1)) - 1);
            rchk(r_flg, 32'h0, "flag early");
            ticks(1);
            rchk(r_flg, 32'h1, "flag on interval");
            wr(r_flg, 8'h0);
            rchk(r_flg, 32'h1, "flag kept");
            wr(r_flg, 8'h1);
            rchk(r_flg, 32'h0, "flag cleared");
        end
    endtask : s_period

    // Period off, reserved period and disabled timer give no events.
    task s_off;
        logic [7:0] cs [3] = '{8'h01, 8'h79, 8'h08};
        foreach (cs[i]) begin
            pit_setup(cs[i]);
            ticks(40);
            rchk(r_flg, 32'h0, "no event");
        end
    endtask : s_off

    task s_irq;
        pit_setup(8'h09);
        wr(r_ien, 8'h1);
        rchk(r_ien, 32'h1, "irq enable");
        ticks(4);
        repeat (3) @(posedge hclk);
        chk("irq request", 32'h1, {31'h0, periodic_irq_req});
        wr(r_ien, 8'h0);
        repeat (3) @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, periodic_irq_req});
        wr(r_ien, 8'h1);
        repeat (3) @(posedge hclk);
        chk("irq unmasked", 32'h1, {31'h0, periodic_irq_req});
        wr(r_flg, 8'h1);
        repeat (3) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, periodic_irq_req});
        wr(r_ien, 8'h0);
    endtask : s_irq

    task s_debug;
        wr(r_dbg, 8'h0);
        pit_setup(8'h09);
        debug_halt <= 1'b1;
        ticks(8);
        rchk(r_flg, 32'h0, "halted timer");
        wr(r_dbg, 8'h1);
        rchk(r_dbg, 32'h1, "debug run");
        ticks(3);
        rchk(r_flg, 32'h0, "run under halt early");
        ticks(1);
        rchk(r_flg, 32'h1, "run under halt");
        debug_halt <= 1'b0;
    endtask : s_debug

    // Clock enable low freezes the timer; counting resumes where it stood.
    task s_freeze;
        pit_setup(8'h09);
        ce <= 1'b0;
        ticks(8);
        ce <= 1'b1;
        rchk(r_flg, 32'h0, "frozen timer");
        ticks(4);
        rchk(r_flg, 32'h1, "thawed timer");
    endtask : s_freeze

    task s_cmp;
        wr(`RTCPIT_IDX_CMP_LO, 8'h34);
        wr(`RTCPIT_IDX_CMP_HI, 8'h12);
        counter_value <= 16'h1233;
        ticks(1);
        rchk(r_cfl, 32'h0, "no match");
        counter_value <= 16'h1234;
        ticks(1);
        rchk(r_cfl, 32'h2, "match flag");
        chk("match output", 32'h1, {31'h0, compare_match});
        wr(r_cfl, 8'h2);
        repeat (3) @(posedge hclk);
        chk("match output cleared", 32'h0, {31'h0, compare_match});
        rchk(r_cfl, 32'h0, "match flag cleared");
    endtask : s_cmp

    // =============================================================
    // Verdict and run control.
    task tally_and_finish;
        $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_regs;
        s_sync;
        s_period;
        s_off;
        s_irq;
        s_debug;
        s_freeze;
        s_cmp;
        tally_and_finish;
    end

    // Watchdog well beyond the several hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
